/* File: rtl/fsr_pkg.sv */
// Constants, field layouts and types for the flow-through burst memory port.
// Assumes a single 125 MHz clock; the memory depth and word width are fixed.
`default_nettype none

package fsr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry.
   localparam int ADDR_W = 18;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = LANES * LANE_W;
   localparam int MEM_DEPTH = 262144;
   localparam int OFF_W = 2;
   localparam int OFF_LSB = 0;
   localparam int BASE_LSB = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing. One device cycle is one mclk period.
   localparam int CLK_PERIOD_NS = 8;
   localparam int SLEEP_ENTER_NS = 2 * CLK_PERIOD_NS;
   localparam int SLEEP_EXIT_NS = 2 * CLK_PERIOD_NS;
   localparam int SLEEP_ENTER_CYC = (SLEEP_ENTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] SLEEP_ENTER_LAST = 2'(SLEEP_ENTER_CYC - 1);
   localparam logic [1:0] SLEEP_EXIT_LAST = 2'(SLEEP_EXIT_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [1:0] RST_COUNT = 2'h0;
   localparam logic [WORD_W-1:0] RST_WORD = 36'h0;
   localparam logic [ADDR_W-1:0] RST_ADDR = 18'h0;
   localparam logic [LANES-1:0] RST_MASK = 4'h0;
   // Drive enable stage (bit 1) comes out of reset inactive.
   localparam logic [2:0] RST_SYNC = 3'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum {OP_IDLE, OP_READ, OP_WRITE} fsr_op_t;
   typedef enum {SLP_AWAKE, SLP_ENTER, SLP_ASLEEP, SLP_EXIT} fsr_slp_t;

   // One pending write: lane i is {parity bit, data byte}; mask is active high.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] mask;
      logic [WORD_W-1:0] data;
   } fsr_wentry_t;

endpackage : fsr_pkg

`default_nettype wire

/* File: rtl/fsr_buf_if.sv */
// Carrier between the port logic and its two-entry write buffer.
// Assumes both ends sit on the same clock; the interface holds no logic.
`default_nettype none

interface fsr_buf_if;
   import fsr_pkg::*;
   logic push_valid;
   logic push_ready;
   fsr_wentry_t push_data;
   logic pop_valid;
   logic pop_ready;
   fsr_wentry_t pop_data;
   logic [1:0] peek_valid;
   fsr_wentry_t peek_data [2];

   modport prod (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data, peek_valid, peek_data);
   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, peek_valid, peek_data);
endinterface : fsr_buf_if

`default_nettype wire

/* File: rtl/fsr_wbuf.sv */
// Two-entry write buffer between the pin data capture and the array.
// Assumes a synchronous active-high reset; entry 0 is always the oldest.
`default_nettype none

module fsr_wbuf
   import fsr_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Buffer ports.
   fsr_buf_if.store bq
);

   logic [1:0] count_r;
   fsr_wentry_t ent_r [2];
   logic do_push;
   logic do_pop;
   logic wr_idx;

   assign bq.push_ready = (count_r != 2'h2);
   assign bq.pop_valid = (count_r != 2'h0);
   assign bq.pop_data = ent_r[0];
   assign bq.peek_valid = {count_r == 2'h2, count_r != 2'h0};
   assign bq.peek_data = ent_r;
   assign do_push = bq.push_valid & bq.push_ready;
   assign do_pop = bq.pop_valid & bq.pop_ready;
   assign wr_idx = do_pop ? 1'b0 : (count_r == 2'h1);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_r <= RST_COUNT;
      end else begin
         count_r <= 2'(count_r + {1'b0, do_push} - {1'b0, do_pop});
      end
   end

   // Entries carry no control meaning, so they are left out of reset.
   always_ff @(posedge mclk) begin
      if (do_pop) begin
         ent_r[0] <= ent_r[1];
      end
      if (do_push) begin
         ent_r[wr_idx] <= bq.push_data;
      end
   end

endmodule : fsr_wbuf

`default_nettype wire

/* File: rtl/fsr_port.sv */
// Flow-through burst static memory: pin-level port logic and storage array.
// Assumes synchronous pins are timed to mclk; sleep, output drive enable and
// burst order strap are asynchronous and are synchronised here.
//
// Behaviour
// - Stalled edge holds burst state, except sleep entry, which clears the operation to idle.
// - All synchronous inputs captured on rising edge.
// - Selected, write strobe high, load: read.
// - Read word appears the cycle after.
// - Read data driven only while enable low.
// - Any chip select inactive: deselect, release bus.
// - New operation accepted every edge, no idle.
// - Burst counter changes two low bits, wraps.
// - Order strap low linear, high interleaved.
// - Advance edge increments, ignores selects, strobe.
// - Access type fixed for whole burst.
// - Selected, write strobe low: write, release bus.
// - Write data captured the following edge.
// - Only selected lanes and parity written.
// - Outputs released during write data phase.
// - Sleep preserves data; two cycles each way.
// - Accesses pending at sleep are dropped.
// - Interleaved beat offset is start xor count.
// - Linear beat offset counts up, wraps.
// - Outputs released first clock after deselect.
// - Starts deselected with outputs released.
`default_nettype none

module fsr_port
   import fsr_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Synchronous control pins.
   input wire logic clock_qualifier_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic advance_or_load,
   input wire logic write_enable_n,
   input wire logic [LANES-1:0] byte_lane_select_n,
   input wire logic [ADDR_W-1:0] address,
   // Asynchronous pins.
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_select,
   // Shared data bus, split into input, output and enable.
   input wire logic [31:0] data_in,
   output logic [31:0] data_out,
   output logic data_oe,
   input wire logic [LANES-1:0] lane_parity_lines_in,
   output logic [LANES-1:0] lane_parity_lines_out,
   output logic lane_parity_lines_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Offset of the given beat within a four-beat burst.
   function automatic logic [OFF_W-1:0] beat_offset(input logic [OFF_W-1:0] start,
                                                    input logic [OFF_W-1:0] beat,
                                                    input logic interleave);
      if (interleave) begin
         beat_offset = start ^ beat;
      end else begin
         beat_offset = OFF_W'(start + beat);
      end
   endfunction : beat_offset

   // Overlay the enabled lanes of a pending write onto an older word.
   function automatic logic [WORD_W-1:0] overlay(input logic [WORD_W-1:0] old,
                                                 input fsr_wentry_t ent,
                                                 input logic hit);
      logic [WORD_W-1:0] res;
      res = old;
      for (int i = 0; i < LANES; i++) begin
         if (hit && ent.mask[i]) begin
            res[i*LANE_W +: LANE_W] = ent.data[i*LANE_W +: LANE_W];
         end
      end
      overlay = res;
   endfunction : overlay

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the asynchronous pins: bit 0 sleep, 1 drive enable,
   // 2 order strap. A level is accepted once stages two and three agree.

   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   logic [2:0] filt_r;
   logic sleep_lvl;
   logic oe_n_lvl;
   logic interleave;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1_r <= RST_SYNC;
         sync2_r <= RST_SYNC;
         sync3_r <= RST_SYNC;
      end else begin
         sync1_r <= {burst_order_select, output_enable_n, sleep_request};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Reset leaves the drive enable seen as inactive so the bus stays released.
   // The agreement filter costs a cycle of latency but rejects one-cycle glitches.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         filt_r <= RST_SYNC;
      end else begin
         filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
      end
   end

   assign sleep_lvl = filt_r[0];
   assign oe_n_lvl = filt_r[1];
   assign interleave = filt_r[2];

   ////////////////////////////////////////////////////////////////////////////
   // Sleep sequencing.

   fsr_slp_t slp_r;
   logic [1:0] slp_cnt_r;
   logic sleep_abort;
   logic awake;

   assign awake = (slp_r == SLP_AWAKE);
   assign sleep_abort = awake & sleep_lvl;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         slp_r <= SLP_AWAKE;
         slp_cnt_r <= RST_COUNT;
      end else begin
         case (slp_r)
            SLP_AWAKE: begin
               slp_cnt_r <= RST_COUNT;
               if (sleep_lvl) begin
                  slp_r <= SLP_ENTER;
               end
            end
            SLP_ENTER: begin
               slp_cnt_r <= 2'(slp_cnt_r + 2'h1);
               if (slp_cnt_r == SLEEP_ENTER_LAST) begin
                  slp_r <= SLP_ASLEEP;
                  slp_cnt_r <= RST_COUNT;
               end
            end
            SLP_ASLEEP: begin
               if (!sleep_lvl) begin
                  slp_r <= SLP_EXIT;
               end
            end
            SLP_EXIT: begin
               slp_cnt_r <= 2'(slp_cnt_r + 2'h1);
               if (sleep_lvl) begin
                  slp_r <= SLP_ENTER;
                  slp_cnt_r <= RST_COUNT;
               end else if (slp_cnt_r == SLEEP_EXIT_LAST) begin
                  slp_r <= SLP_AWAKE;
                  slp_cnt_r <= RST_COUNT;
               end
            end
            default: begin
               slp_r <= SLP_AWAKE;
               slp_cnt_r <= RST_COUNT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge qualification and operation decode.

   fsr_buf_if bq ();

   fsr_op_t op_r;
   logic [ADDR_W-1:BASE_LSB] base_r;
   logic [OFF_W-1:0] start_r;
   logic [OFF_W-1:0] beat_r;
   logic [OFF_W-1:0] beat_nxt;
   logic wr_pend_r;
   logic [ADDR_W-1:0] wr_addr_r;
   logic [LANES-1:0] wr_mask_r;
   logic q_edge;
   logic sel_all;
   logic load;
   logic cont_act;
   logic acc_rd;
   logic acc_wr;
   logic [ADDR_W-1:0] acc_addr;

   // A full buffer can only occur while the array sleeps; the edge is then
   // stalled rather than losing a captured word.
   assign q_edge = ~clock_qualifier_n & awake & ~sleep_lvl
                   & (~wr_pend_r | bq.push_ready);
   assign sel_all = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;
   assign load = q_edge & ~advance_or_load;
   assign cont_act = q_edge & advance_or_load & (op_r != OP_IDLE);
   assign beat_nxt = OFF_W'(beat_r + 2'h1);
   assign acc_rd = (load & sel_all & write_enable_n)
                   | (cont_act & (op_r == OP_READ));
   assign acc_wr = (load & sel_all & ~write_enable_n)
                   | (cont_act & (op_r == OP_WRITE));
   assign acc_addr = load ? address
                     : {base_r, beat_offset(start_r, beat_nxt, interleave)};

   // Burst state: loaded on a load edge, advanced on a continue edge, held
   // on every stalled edge except sleep entry, which clears the operation to idle.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         op_r <= OP_IDLE;
         base_r <= RST_ADDR[ADDR_W-1:BASE_LSB];
         start_r <= RST_COUNT;
         beat_r <= RST_COUNT;
      end else if (sleep_abort) begin
         op_r <= OP_IDLE;
      end else if (load) begin
         beat_r <= RST_COUNT;
         if (sel_all) begin
            op_r <= write_enable_n ? OP_READ : OP_WRITE;
            base_r <= address[ADDR_W-1:BASE_LSB];
            start_r <= address[OFF_W-1:OFF_LSB];
         end else begin
            op_r <= OP_IDLE;
         end
      end else if (cont_act) begin
         beat_r <= beat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write pipeline: address and lane selects at one edge, data at the next.

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= RST_ADDR;
         wr_mask_r <= RST_MASK;
      end else if (sleep_abort) begin
         wr_pend_r <= 1'b0;
      end else if (q_edge) begin
         wr_pend_r <= acc_wr;
         if (acc_wr) begin
            wr_addr_r <= acc_addr;
            wr_mask_r <= ~byte_lane_select_n;
         end
      end
   end

   always_comb begin
      bq.push_valid = q_edge & wr_pend_r;
      bq.push_data.addr = wr_addr_r;
      bq.push_data.mask = wr_mask_r;
      for (int i = 0; i < LANES; i++) begin
         bq.push_data.data[i*LANE_W +: LANE_W] = {lane_parity_lines_in[i], data_in[i*8 +: 8]};
      end
   end

   // The array is powered down while asleep, so draining pauses there.
   assign bq.pop_ready = (slp_r != SLP_ASLEEP);

   fsr_wbuf u_wbuf (
      .mclk (mclk),
      .sys_rst (sys_rst),
      .bq (bq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Storage array. Stored words are kept across sleep.

   logic [WORD_W-1:0] mem_r [MEM_DEPTH];

   always_ff @(posedge mclk) begin
      if (bq.pop_valid && bq.pop_ready) begin
         for (int i = 0; i < LANES; i++) begin
            if (bq.pop_data.mask[i]) begin
               mem_r[bq.pop_data.addr][i*LANE_W +: LANE_W]
                  <= bq.pop_data.data[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path. Writes still in the buffer, and the word being captured at
   // this very edge, are overlaid in age order so a read never sees stale data.

   logic [WORD_W-1:0] rd_word;
   logic [WORD_W-1:0] data_out_r;
   logic rd_valid_r;
   logic drive;

   always_comb begin
      rd_word = mem_r[acc_addr];
      for (int k = 0; k < 2; k++) begin
         rd_word = overlay(rd_word, bq.peek_data[k],
                           bq.peek_valid[k] && (bq.peek_data[k].addr == acc_addr));
      end
      rd_word = overlay(rd_word, bq.push_data, wr_pend_r && (wr_addr_r == acc_addr));
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_valid_r <= 1'b0;
         data_out_r <= RST_WORD;
      end else if (sleep_abort) begin
         rd_valid_r <= 1'b0;
      end else if (q_edge) begin
         rd_valid_r <= acc_rd;
         if (acc_rd) begin
            data_out_r <= rd_word;
         end
      end
   end

   // Only the data phase of a read drives the bus; deselect, write data
   // phases and the cycle of a first load after deselect all leave it off.
   assign drive = rd_valid_r & ~oe_n_lvl & awake;
   assign data_oe = drive;
   assign lane_parity_lines_oe = drive;

   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         data_out[i*8 +: 8] = data_out_r[i*LANE_W +: 8];
         lane_parity_lines_out[i] = data_out_r[i*LANE_W + 8];
      end
   end

endmodule : fsr_port

`default_nettype wire

/* File: dv/fsr_port_props.sv */
// Concurrent checks on the pins of the flow-through burst memory port.
// Assumes one clock; bursts are judged only well clear of reset and sleep.
`default_nettype none

module fsr_port_props
   import fsr_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Control pins.
   input wire logic clock_qualifier_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic advance_or_load,
   input wire logic write_enable_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // Device drive of the shared bus.
   input wire logic [31:0] data_out,
   input wire logic data_oe,
   input wire logic [LANES-1:0] lane_parity_lines_out,
   input wire logic lane_parity_lines_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // Burst kind as seen from the pins: 0 none, 1 read, 2 write.
   logic [1:0] kind_r;
   logic [3:0] quiet_r;
   logic sel;
   logic ok;
   logic taken;
   assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   assign ok = quiet_r == 4'hf;
   assign taken = !clock_qualifier_n && ok;

   // The sleep pin passes synchronisers and a wake-up delay, so the device state is only
   // predictable once the pin has been low for a good while.
   always_ff @(posedge mclk) begin
      if (sys_rst || sleep_request) quiet_r <= 4'h0;
      else if (!ok) quiet_r <= quiet_r + 4'h1;
   end
   always_ff @(posedge mclk) begin
      if (sys_rst || sleep_request) kind_r <= 2'h0;
      else if (!clock_qualifier_n && !advance_or_load)
         kind_r <= !sel ? 2'h0 : (write_enable_n ? 2'h1 : 2'h2);
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_oe_low;
      !output_enable_n [*4];
   endsequence
   sequence s_asleep;
      sleep_request [*8];
   endsequence
   sequence s_read_edge;
      taken && (advance_or_load ? kind_r == 2'h1 : sel && write_enable_n);
   endsequence
   sequence s_write_edge;
      taken && (advance_or_load ? kind_r == 2'h2 : sel && !write_enable_n);
   endsequence

   property p_stall_hold;
      clock_qualifier_n && ok |=> $stable(data_out) && $stable(lane_parity_lines_out);
   endproperty
   property p_read_drives;
      s_oe_low ##0 s_read_edge |=> data_oe && lane_parity_lines_oe;
   endproperty
   property p_write_quiet;
      s_write_edge |=> !data_oe && !lane_parity_lines_oe;
   endproperty
   property p_phase_stall;
      s_write_edge ##1 clock_qualifier_n [*2] |-> !data_oe;
   endproperty
   property p_desel_quiet;
      taken && (advance_or_load ? kind_r == 2'h0 : !sel) |=> !data_oe;
   endproperty
   property p_oe_off;
      output_enable_n [*4] |=> !data_oe && !lane_parity_lines_oe;
   endproperty
   property p_sleep_quiet;
      s_asleep |-> !data_oe;
   endproperty
   property p_reset_idle;
      $fell(sys_rst) |-> !data_oe && data_out == 32'h0;
   endproperty
   property p_lanes_agree;
      data_oe == lane_parity_lines_oe;
   endproperty

   a_stall_hold: assert property (p_stall_hold) else $error("outputs moved on stall");
   a_read_drives: assert property (p_read_drives) else $error("read not driven");
   a_write_quiet: assert property (p_write_quiet) else $error("write drove bus");
   a_phase_stall: assert property (p_phase_stall) else $error("drive in data phase");
   a_desel_quiet: assert property (p_desel_quiet) else $error("deselect drove bus");
   a_oe_off: assert property (p_oe_off) else $error("drive with enable high");
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("drive while asleep");
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
   a_lanes_agree: assert property (p_lanes_agree) else $error("lane enables differ");
endmodule : fsr_port_props

bind fsr_port fsr_port_props u_fsr_port_props (.mclk(mclk), .sys_rst(sys_rst),
   .clock_qualifier_n(clock_qualifier_n), .chip_select_first_n(chip_select_first_n),
   .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
   .advance_or_load(advance_or_load), .write_enable_n(write_enable_n),
   .output_enable_n(output_enable_n), .sleep_request(sleep_request),
   .data_out(data_out), .data_oe(data_oe), .lane_parity_lines_out(lane_parity_lines_out),
   .lane_parity_lines_oe(lane_parity_lines_oe));

`default_nettype wire

/* File: dv/fsr_ctl_model.sv */
// Controller side of the shared data and parity bus.
// Assumes the bench says when the controller drives; this resolves the wire levels.
`default_nettype none

module fsr_ctl_model
   import fsr_pkg::*;
(
   // Clock.
   input wire logic mclk,
   // Controller drive request, lane i is {parity, byte}.
   input wire logic drv_en,
   input wire logic [WORD_W-1:0] drv_word,
   // Device drive.
   input wire logic [31:0] data_out,
   input wire logic data_oe,
   input wire logic [LANES-1:0] par_out,
   input wire logic par_oe,
   // Levels seen by the device.
   output logic [31:0] data_in,
   output logic [LANES-1:0] par_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // The bus has no keeper, so a released bus shows a pattern that flips every cycle.
   logic [WORD_W-1:0] float_r = 36'h5a5a5a5a5;
   logic [WORD_W-1:0] dev_w;
   logic [WORD_W-1:0] bus_w;
   always @(posedge mclk) float_r <= ~float_r;

   always_comb begin
      for (int i = 0; i < LANES; i++) dev_w[i*LANE_W +: LANE_W] = {par_out[i], data_out[i*8 +: 8]};
      if (drv_en && (data_oe || par_oe)) bus_w = 'x;
      else if (drv_en) bus_w = drv_word;
      else if (data_oe || par_oe) bus_w = dev_w;
      else bus_w = float_r;
      for (int i = 0; i < LANES; i++) begin
         data_in[i*8 +: 8] = bus_w[i*LANE_W +: 8];
         par_in[i] = bus_w[i*LANE_W + 8];
      end
   end
endmodule : fsr_ctl_model

`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the burst memory port: bursts in both orders, lanes, stalls, sleep.
// Assumes the controller model resolves the bus; expectations come from a memory model.
`default_nettype none

module testbench
   import fsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {logic oe; logic [WORD_W-1:0] val;} fsr_exp_t;

   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic clock_qualifier_n = 1'b1;
   logic chip_select_first_n = 1'b1;
   logic chip_select_second = 1'b0;
   logic chip_select_third_n = 1'b1;
   logic advance_or_load = 1'b0;
   logic write_enable_n = 1'b1;
   logic [LANES-1:0] byte_lane_select_n = '1;
   logic [ADDR_W-1:0] address = '0;
   logic output_enable_n = 1'b0;
   logic sleep_request = 1'b0;
   logic burst_order_select = 1'b0;
   logic [31:0] data_in, data_out;
   logic [LANES-1:0] lane_parity_lines_in, lane_parity_lines_out;
   logic data_oe, lane_parity_lines_oe;
   logic drv_en = 1'b0;
   logic [WORD_W-1:0] drv_word = '0;

   fsr_exp_t exp_q [$];
   logic [WORD_W-1:0] mem_m [logic [ADDR_W-1:0]];
   logic [31:0] lfsr_r = 32'hb234cf9f;
   int n_errors = 0;
   int comparisons = 0;
   int cyc_cnt = 0;
   logic bur_act = 1'b0, bur_wr = 1'b0, pend_v = 1'b0, slp_hold = 1'b0, taken_d = 1'b0;
   logic [ADDR_W-1:0] bur_base = '0, pend_a = '0;
   logic [1:0] bur_beat = 2'h0;
   logic [LANES-1:0] pend_m = '0;

   always #4 mclk = ~mclk;

   fsr_port u_fsr_port (.mclk(mclk), .sys_rst(sys_rst), .clock_qualifier_n(clock_qualifier_n),
      .chip_select_first_n(chip_select_first_n), .chip_select_second(chip_select_second),
      .chip_select_third_n(chip_select_third_n), .advance_or_load(advance_or_load),
      .write_enable_n(write_enable_n), .byte_lane_select_n(byte_lane_select_n),
      .address(address), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
      .burst_order_select(burst_order_select), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .lane_parity_lines_in(lane_parity_lines_in),
      .lane_parity_lines_out(lane_parity_lines_out),
      .lane_parity_lines_oe(lane_parity_lines_oe));

   fsr_ctl_model u_fsr_ctl_model (.mclk(mclk), .drv_en(drv_en), .drv_word(drv_word),
      .data_out(data_out), .data_oe(data_oe), .par_out(lane_parity_lines_out),
      .par_oe(lane_parity_lines_oe), .data_in(data_in), .par_in(lane_parity_lines_in));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction : rnd

   function automatic logic [ADDR_W-1:0] beat_addr(input logic [1:0] b);
      logic [1:0] st;
      st = bur_base[1:0];
      return {bur_base[ADDR_W-1:2], burst_order_select ? st ^ b : st + b};
   endfunction : beat_addr

   function automatic logic [WORD_W-1:0] pack(input logic [31:0] d, input logic [LANES-1:0] p);
      for (int i = 0; i < LANES; i++) pack[i*LANE_W +: LANE_W] = {p[i], d[i*8 +: 8]};
   endfunction : pack

   task automatic check(input string what, input logic [WORD_W-1:0] exp,
                        input logic [WORD_W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   // Ignored edges carry garbage on the control pins; selects stay off around sleep.
   task automatic stall(input int n);
      repeat (n) begin
         @(posedge mclk);
         clock_qualifier_n <= 1'b1;
         chip_select_first_n <= 1'(rnd()) | slp_hold;
         {advance_or_load, write_enable_n} <= 2'(rnd());
         address <= ADDR_W'(rnd());
         byte_lane_select_n <= LANES'(rnd());
      end
   endtask : stall

   // One taken edge; the expected output after it is queued.
   task automatic cyc(input logic sel, input logic adv, input logic we_n,
                      input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln_n);
      fsr_exp_t e;
      logic [WORD_W-1:0] w;
      if (rnd() % 5 == 0) stall(rnd() % 3 + 1);
      @(posedge mclk);
      w = WORD_W'({rnd(), rnd()});
      drv_en <= pend_v;
      drv_word <= w;
      if (pend_v) begin
         for (int i = 0; i < LANES; i++) begin
            if (pend_m[i]) mem_m[pend_a][i*LANE_W +: LANE_W] = w[i*LANE_W +: LANE_W];
         end
      end
      pend_v = 1'b0;
      e = '0;
      clock_qualifier_n <= 1'b0;
      chip_select_first_n <= !sel;
      chip_select_second <= sel;
      chip_select_third_n <= !sel;
      advance_or_load <= adv;
      write_enable_n <= we_n;
      address <= a;
      byte_lane_select_n <= ln_n;
      if (adv) begin
         bur_beat = bur_beat + 2'h1;
      end else begin
         bur_act = sel;
         bur_wr = !we_n;
         bur_base = a;
         bur_beat = 2'h0;
      end
      if (bur_act && bur_wr) begin
         pend_v = 1'b1;
         pend_a = beat_addr(bur_beat);
         pend_m = ~ln_n;
      end else if (bur_act) begin
         e.oe = !output_enable_n;
         e.val = mem_m[beat_addr(bur_beat)];
      end
      exp_q.push_back(e);
   endtask : cyc

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin : mon
      fsr_exp_t e;
      if (taken_d && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("data_oe", WORD_W'(e.oe), WORD_W'(data_oe));
         check("lane_parity_lines_oe", WORD_W'(e.oe), WORD_W'(lane_parity_lines_oe));
         if (e.oe) check("read word", e.val, pack(data_out, lane_parity_lines_out));
      end
      taken_d <= !clock_qualifier_n && !sys_rst;
   end

   always @(posedge mclk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         n_errors++;
         summarize();
      end
   end

   initial begin : main
      logic [ADDR_W-1:0] a;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      stall(4);
      repeat (4) cyc(1, 1, 0, '0, '0);
      for (int o = 0; o < 2; o++) begin
         burst_order_select <= o[0];
         repeat (5) cyc(0, 0, 1, '0, '1);
         for (int s = 0; s < 4; s++) begin
            a = {16'(s * 3 + 5), s[1:0]};
            cyc(1, 0, 0, a, o ? LANES'(rnd()) : '0);
            repeat (4) cyc(1'(rnd()), 1, 1'(rnd()), ADDR_W'(rnd()), o ? LANES'(rnd()) : '0);
            cyc(1, 0, 1, a, '1);
            repeat (4) cyc(1'(rnd()), 1, 1'(rnd()), ADDR_W'(rnd()), '1);
         end
      end
      output_enable_n <= 1'b1;
      repeat (4) cyc(0, 0, 1, '0, '1);
      cyc(1, 0, 1, {16'h5, 2'h0}, '1);
      output_enable_n <= 1'b0;
      repeat (4) cyc(0, 0, 1, '0, '1);
      slp_hold = 1'b1;
      sleep_request <= 1'b1;
      stall(10);
      sleep_request <= 1'b0;
      stall(8);
      slp_hold = 1'b0;
      cyc(1, 0, 1, {16'h8, 2'h1}, '1);
      repeat (3) cyc(0, 1, 1, '0, '1);
      repeat (2) cyc(0, 0, 1, '0, '1);
      stall(3);
      n_errors += exp_q.size();
      summarize();
   end
endmodule : testbench

`default_nettype wire
